/* design/ppm_pkg.sv */
/*
  Shared constants and carriers for the port pin override multiplexer.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none
package ppm_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] PPM_OFS_DIR     = 8'h00;
  localparam logic [7:0] PPM_OFS_OUT     = 8'h04;
  localparam logic [7:0] PPM_OFS_PIN     = 8'h08;
  localparam logic [7:0] PPM_OFS_CTRL    = 8'h0C;
  localparam int         PPM_CTRL_PUOFF  = 0;

  // ****************************************************
  // Reset values and dedicated pins
  // ****************************************************
  localparam logic [7:0] PPM_DIR_RST     = 8'h00;
  localparam logic [7:0] PPM_OUT_RST     = 8'h00;
  localparam logic       PPM_CTRL_RST    = 1'b0;
  localparam int         PPM_RESET_BIT   = 7;
  localparam int         PPM_CLOCK_BIT   = 6;
  localparam int         PPM_WIDTH       = 8;

  // ****************************************************
  // Per-pin override carrier, one bit per pin
  // ****************************************************
  typedef struct packed {
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] dir_override_en;
    logic [7:0] dir_override_val;
    logic [7:0] level_override_en;
    logic [7:0] level_override_val;
    logic [7:0] toggle_override_en;
    logic [7:0] input_gate_override_en;
    logic [7:0] input_gate_override_val;
  } ppm_override_type;

  // Pad-side drive controls
  typedef struct packed {
    logic [7:0] drive_en;
    logic [7:0] drive_val;
    logic [7:0] pullup_en;
  } ppm_pad_ctrl_type;

endpackage
`default_nettype wire

/* design/ppm_port.sv */
/*
  One 8-bit general-purpose port with alternate-function overrides,
  APB register slave, input synchroniser and pin-change sources.
  Registers: direction, output value, pin readback with write-one
  toggle, and a control word holding the global pull-up disable.
  The slave answers with zero wait states; read data is taken in the
  setup cycle, so it stands through the whole access phase.
  Assumes override signals, sleep clamp and strap inputs arrive on the
  same clock; pad inputs are asynchronous.
  Assumes the pad cell turns pullup_en, drive_en and drive_val into
  pad behaviour and feeds the pad level back on pad_in.
*/
// How it works
// - No override: pullup when dir,out,puoff = 010
// - Override enable: pullup follows override value
// - Driver enable from override or direction bit
// - Level override value drives enabled pin
// - Otherwise output bit drives enabled pin
// - Toggle override inverts stored output bit
// - Input enable follows sleep clamp by default
// - Input gate override sets input enable
// - Raw tap after Schmitt, before synchroniser
// - Analog line connects straight to pad
// - Strobes per port, overrides per pin
// - Pull-ups off while reset is held
// - Pins 0..7 feed pin-change group 0
// - Reset pin: pullup on, driver/input off
// - Clock input pin loses general-purpose use
// - Deep sleep clamps inputs unless overridden
`timescale 1ns/100ps
`default_nettype none
module ppm_port (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire ppm_pkg::ppm_override_type ovr,
  input  wire logic                      sleep_clamp,
  input  wire logic                      reset_pin_disable_fuse,
  input  wire logic                      ext_clock_sel,
  input  wire logic [7:0]                pad_in,
  output ppm_pkg::ppm_pad_ctrl_type      pad_ctrl,
  output logic [7:0]                     schmitt_input_tap,
  output logic [7:0]                     analog_pad_line,
  output logic [7:0]                     pin_change_source,
  output logic                           ext_clock_in
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic ofs_hit(input logic [7:0] a,
                                   input logic [7:0] o);
    ofs_hit = (a == o);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0]  dir_bit_r;
  logic [7:0]  dir_bit_nxt;
  logic [7:0]  out_value_bit_r;
  logic [7:0]  out_value_bit_nxt;
  logic        global_pullup_off_r;
  logic        global_pullup_off_nxt;
  logic [7:0]  sync1_r;
  logic [7:0]  sync2_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        slverr_r;
  logic        slverr_nxt;
  logic [7:0]  sync1_nxt;
  logic [7:0]  sync2_nxt;

  logic        setup_ph;
  logic        wr_acc;
  logic        hit_dir;
  logic        hit_out;
  logic        hit_pin;
  logic        hit_ctrl;
  logic        mapped;
  logic        reset_pin_on;
  logic        clock_pin_on;
  logic [7:0]  sw_toggle;
  logic [7:0]  eff_pu_en;
  logic [7:0]  eff_pu_val;
  logic [7:0]  eff_dd_en;
  logic [7:0]  eff_dd_val;
  logic [7:0]  eff_pv_en;
  logic [7:0]  eff_pv_val;
  logic [7:0]  eff_di_en;
  logic [7:0]  eff_di_val;
  logic [7:0]  input_en;
  logic [7:0]  drive_en;
  logic [7:0]  drive_val;
  logic [7:0]  pullup_en;
  logic [7:0]  gated_in;

  // ****************************************************
  // APB decode
  // ****************************************************
  // Zero wait states; read data captured in the setup cycle.
  // Unmapped offsets read zero and flag pslverr when accessed
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign hit_dir  = ofs_hit(paddr, ppm_pkg::PPM_OFS_DIR);
  assign hit_out  = ofs_hit(paddr, ppm_pkg::PPM_OFS_OUT);
  assign hit_pin  = ofs_hit(paddr, ppm_pkg::PPM_OFS_PIN);
  assign hit_ctrl = ofs_hit(paddr, ppm_pkg::PPM_OFS_CTRL);
  assign mapped   = hit_dir | hit_out | hit_pin | hit_ctrl;

  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (setup_ph) begin
      slverr_nxt = ~mapped;
      prdata_nxt = 32'h0000_0000;
      if (hit_dir) begin
        prdata_nxt[7:0] = dir_bit_r;
      end
      if (hit_out) begin
        prdata_nxt[7:0] = out_value_bit_r;
      end
      if (hit_pin) begin
        prdata_nxt[7:0] = sync2_r;
      end
      if (hit_ctrl) begin
        prdata_nxt[ppm_pkg::PPM_CTRL_PUOFF] = global_pullup_off_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // ****************************************************
  // Port registers
  // ****************************************************
  // Writing ones to the pin readback flips those output bits
  assign sw_toggle = (wr_acc && hit_pin) ? pwdata[7:0] : 8'h00;

  // One set of strobes serves all eight pins.
  always_comb begin
    dir_bit_nxt           = dir_bit_r;
    out_value_bit_nxt     = out_value_bit_r;
    global_pullup_off_nxt = global_pullup_off_r;
    if (wr_acc && hit_dir) begin
      dir_bit_nxt = pwdata[7:0];
    end
    if (wr_acc && hit_out) begin
      out_value_bit_nxt = pwdata[7:0];
    end
    if (wr_acc && hit_ctrl) begin
      global_pullup_off_nxt = pwdata[ppm_pkg::PPM_CTRL_PUOFF];
    end
    // Software toggle and peripheral toggle combine by XOR
    out_value_bit_nxt = out_value_bit_nxt ^ sw_toggle;
    out_value_bit_nxt = out_value_bit_nxt ^ ovr.toggle_override_en;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dir_bit_r           <= ppm_pkg::PPM_DIR_RST;
      out_value_bit_r     <= ppm_pkg::PPM_OUT_RST;
      global_pullup_off_r <= ppm_pkg::PPM_CTRL_RST;
    end else begin
      dir_bit_r           <= dir_bit_nxt;
      out_value_bit_r     <= out_value_bit_nxt;
      global_pullup_off_r <= global_pullup_off_nxt;
    end
  end

  // ****************************************************
  // Strap pins
  // ****************************************************
  // Straps are static levels and outrank peripheral overrides, except the level override on the reset pin
  assign reset_pin_on = ~reset_pin_disable_fuse;
  assign clock_pin_on = ext_clock_sel;

  // ****************************************************
  // Dedicated-pin overrides
  // ****************************************************
  // Reset pin replaces pull-up, driver and input-gate overrides; clock pin also the level override.
  always_comb begin
    eff_pu_en  = ovr.pullup_override_en;
    eff_pu_val = ovr.pullup_override_val;
    eff_dd_en  = ovr.dir_override_en;
    eff_dd_val = ovr.dir_override_val;
    eff_pv_en  = ovr.level_override_en;
    eff_pv_val = ovr.level_override_val;
    eff_di_en  = ovr.input_gate_override_en;
    eff_di_val = ovr.input_gate_override_val;
    if (reset_pin_on) begin
      eff_pu_en[ppm_pkg::PPM_RESET_BIT]  = 1'b1;
      eff_pu_val[ppm_pkg::PPM_RESET_BIT] = 1'b1;
      eff_dd_en[ppm_pkg::PPM_RESET_BIT]  = 1'b1;
      eff_dd_val[ppm_pkg::PPM_RESET_BIT] = 1'b0;
      eff_di_en[ppm_pkg::PPM_RESET_BIT]  = 1'b1;
      eff_di_val[ppm_pkg::PPM_RESET_BIT] = 1'b0;
    end
    // Input stays on so the clock keeps running
    if (clock_pin_on) begin
      eff_pu_en[ppm_pkg::PPM_CLOCK_BIT]  = 1'b1;
      eff_pu_val[ppm_pkg::PPM_CLOCK_BIT] = 1'b0;
      eff_dd_en[ppm_pkg::PPM_CLOCK_BIT]  = 1'b1;
      eff_dd_val[ppm_pkg::PPM_CLOCK_BIT] = 1'b0;
      eff_pv_en[ppm_pkg::PPM_CLOCK_BIT]  = 1'b1;
      eff_pv_val[ppm_pkg::PPM_CLOCK_BIT] = 1'b0;
      eff_di_en[ppm_pkg::PPM_CLOCK_BIT]  = 1'b1;
      eff_di_val[ppm_pkg::PPM_CLOCK_BIT] = 1'b1;
    end
  end

  // ****************************************************
  // Pin control muxes
  // ****************************************************
  always_comb begin
    for (int i = 0; i < ppm_pkg::PPM_WIDTH; i++) begin
      if (eff_pu_en[i]) begin
        pullup_en[i] = eff_pu_val[i];
      end else begin
        // Input pin, output bit set, global disable clear
        pullup_en[i] = ({dir_bit_r[i], out_value_bit_r[i],
                         global_pullup_off_r} == 3'h2);
      end
      drive_en[i] = eff_dd_en[i] ? eff_dd_val[i] : dir_bit_r[i];
      if (eff_pv_en[i]) begin
        drive_val[i] = eff_pv_val[i];
      end else begin
        drive_val[i] = out_value_bit_r[i];
      end
      // Sleep clamp shared by all pins, overrides per pin
      if (eff_di_en[i]) begin
        input_en[i] = eff_di_val[i];
      end else begin
        input_en[i] = ~sleep_clamp;
      end
    end
  end

  // ****************************************************
  // Pad outputs
  // ****************************************************
  // Reset forces pull-ups off without waiting for a clock
  // Driver also off in reset, so the pin floats while reset is held
  always_comb begin
    pad_ctrl.pullup_en = pullup_en & {8{~sys_rst}};
    pad_ctrl.drive_en  = drive_en & {8{~sys_rst}};
    pad_ctrl.drive_val = drive_val;
  end

  // ****************************************************
  // Input path
  // ****************************************************
  // Clamp to ground ahead of the Schmitt stage
  assign gated_in          = pad_in & input_en;
  assign schmitt_input_tap = gated_in;
  assign ext_clock_in      = gated_in[ppm_pkg::PPM_CLOCK_BIT];
  // No digital buffering on the analog path
  assign analog_pad_line   = pad_in;

  // Only the second stage reads the first; the first may go metastable
  always_comb begin
    sync1_nxt = gated_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign pin_change_source = sync2_r;

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = slverr_r & psel & penable;

endmodule // ppm_port
`default_nettype wire

/* tb/ppm_port_checker.sv */
/* Pad-control checker for the port override mux.
   Bound to ppm_port; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module ppm_port_checker (
  input wire logic                      clock,
  input wire logic                      sys_rst,
  input wire ppm_pkg::ppm_override_type ovr,
  input wire logic                      sleep_clamp,
  input wire logic                      reset_pin_disable_fuse,
  input wire logic [7:0]                pad_in,
  input wire ppm_pkg::ppm_pad_ctrl_type pad_ctrl,
  input wire logic [7:0]                schmitt_input_tap,
  input wire logic [7:0]                pin_change_source
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ********************
  // Pad controls
  // ********************
  a_pull_reset: assert property (
    disable iff (1'b0) sys_rst |-> {pad_ctrl.pullup_en, pad_ctrl.drive_en} == 16'h0000)
    else $error("pad active in reset");
  // Pins 6 and 7 have strap overrides
  a_pull_ovr: assert property (
    ((pad_ctrl.pullup_en ^ ovr.pullup_override_val)
      & ovr.pullup_override_en & 8'h3F) == 8'h00) else $error("pull-up");
  a_drive_ovr: assert property (
    ((pad_ctrl.drive_en ^ ovr.dir_override_val)
      & ovr.dir_override_en & 8'h3F) == 8'h00) else $error("driver");
  a_level_ovr: assert property (
    ((pad_ctrl.drive_val ^ ovr.level_override_val) & ovr.level_override_en
      & pad_ctrl.drive_en) == 8'h00) else $error("level");
  a_gate_ovr: assert property (
    ((schmitt_input_tap ^ (pad_in & ovr.input_gate_override_val))
      & ovr.input_gate_override_en & 8'h3F) == 8'h00) else $error("gate");
  a_sleep_clamp: assert property (
    sleep_clamp |-> (schmitt_input_tap & ~ovr.input_gate_override_en
      & 8'h3F) == 8'h00) else $error("clamp");
  a_sync_delay: assert property (
    !$past(sys_rst, 2) && !$past(sys_rst) && !$past(sleep_clamp, 2)
      && $past(ovr.input_gate_override_en, 2) == 8'h00
      |-> pin_change_source[5:0] == $past(pad_in[5:0], 2))
    else $error("sync");
  a_reset_pin: assert property (
    !reset_pin_disable_fuse |-> pad_ctrl.pullup_en[7]
      && !pad_ctrl.drive_en[7] && !schmitt_input_tap[7]) else $error("rpin");
endmodule // ppm_port_checker
bind ppm_port ppm_port_checker chk_u (.clock, .sys_rst, .ovr, .sleep_clamp,
  .reset_pin_disable_fuse, .pad_in, .pad_ctrl, .schmitt_input_tap,
  .pin_change_source);
`default_nettype wire

/* tb/ppm_periph_model.sv */
/* Alternate-function peripheral that drives the override bundle.
   Assumes act and tog change just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module ppm_periph_model (
  input  wire logic                 clock,
  input  wire logic                 act,
  input  wire logic                 tog,
  input  wire logic [7:0]           tap,
  output ppm_pkg::ppm_override_type ovr,
  output logic      [7:0]           tap_sync
);
  logic [7:0] meta_r;
  // Raw tap is asynchronous, so resample it twice
  always_ff @(posedge clock) begin
    meta_r   <= tap;
    tap_sync <= meta_r;
  end
  always_comb begin
    ovr = '0;
    if (act) begin
      ovr.pullup_override_en      = 8'hFF;
      ovr.pullup_override_val     = 8'hA5;
      ovr.dir_override_en         = 8'hFF;
      ovr.dir_override_val        = 8'h0F;
      ovr.level_override_en       = 8'hFF;
      ovr.level_override_val      = 8'h3C;
      ovr.input_gate_override_en  = 8'h0F;
      ovr.input_gate_override_val = 8'h05;
    end
    ovr.toggle_override_en = {7'h00, tog};
  end
endmodule // ppm_periph_model
`default_nettype wire

/* tb/ppm_port_test.sv */
/* Self-checking bench for ppm_port over APB.
   Assumes the peripheral model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module ppm_port_test;
  logic                      clock, sys_rst, psel, penable, pwrite, se;
  logic                      pready, pslverr, sleep_clamp, fuse, ext_sel;
  logic                      ext_in, act, tog;
  logic [7:0]                paddr, pad_in, tap, analog, pcs, tsync;
  logic [31:0]               pwdata, prdata, rd;
  int                        err_count, comparisons;
  ppm_pkg::ppm_override_type ovr;
  ppm_pkg::ppm_pad_ctrl_type pc;
  ppm_port dut_u (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ovr, .sleep_clamp,
    .reset_pin_disable_fuse(fuse), .ext_clock_sel(ext_sel), .pad_in,
    .pad_ctrl(pc), .schmitt_input_tap(tap), .analog_pad_line(analog),
    .pin_change_source(pcs), .ext_clock_in(ext_in));
  ppm_periph_model per_u (.clock, .act, .tog, .tap, .ovr, .tap_sync(tsync));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic final_report;
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ********************
  // APB transfer, held until pready
  // ********************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      final_report();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    {sys_rst, fuse} = 2'b11;
    {psel, penable, pwrite, sleep_clamp, ext_sel, act, tog} = 7'h00;
    {paddr, pad_in, pwdata} = 48'h0000_0000_0000;
    err_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    xfer(0, ppm_pkg::PPM_OFS_OUT, 0);
    `CHK("out", 32'h0000_0000, rd)
    xfer(0, 8'h10, 0);
    `CHK("err", 1'b1, se)
    xfer(1, ppm_pkg::PPM_OFS_DIR, 32'h0000_0033);
    xfer(1, ppm_pkg::PPM_OFS_OUT, 32'h0000_0055);
    #1;
    `CHK("pull", 8'h44, pc.pullup_en)
    `CHK("drv", 8'h33, pc.drive_en)
    `CHK("val", 8'h11, pc.drive_val & pc.drive_en)
    xfer(1, ppm_pkg::PPM_OFS_CTRL, 32'h0000_0001);
    #1;
    `CHK("pud", 8'h00, pc.pullup_en)
    xfer(1, ppm_pkg::PPM_OFS_PIN, 32'h0000_000F);
    @(posedge clock);
    tog <= 1'b1;
    @(posedge clock);
    tog <= 1'b0;
    xfer(0, ppm_pkg::PPM_OFS_OUT, 0);
    `CHK("tgl", 32'h0000_005B, rd)
    @(posedge clock);
    {act, sleep_clamp, pad_in} <= 10'h3FF;
    #1;
    `CHK("pull", 8'hA5, pc.pullup_en)
    `CHK("drv", 8'h0F, pc.drive_en)
    `CHK("val", 8'h0C, pc.drive_val & pc.drive_en)
    `CHK("tap", 8'h05, tap)
    `CHK("ana", 8'hFF, analog)
    @(posedge clock);
    {act, sleep_clamp, pad_in} <= 10'h0A6;
    #1;
    `CHK("raw", 8'hA6, tap)
    `CHK("pcs", 8'h00, pcs)
    @(posedge clock);
    #1;
    `CHK("pcs", 8'h05, pcs)
    @(posedge clock);
    #1;
    `CHK("pcs", 8'hA6, pcs)
    `CHK("tsy", 8'hA6, tsync)
    xfer(1, ppm_pkg::PPM_OFS_DIR, 32'h0000_00FF);
    @(posedge clock);
    {fuse, ext_sel, pad_in} <= 10'h1C0;
    #1;
    `CHK("drv", 8'h3F, pc.drive_en)
    `CHK("tap", 8'h40, tap & 8'hC0)
    `CHK("cki", 1'b1, ext_in)
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    #1;
    `CHK("rst", 16'h0000, {pc.drive_en, pc.pullup_en})
    @(posedge clock);
    sys_rst <= 1'b0;
    xfer(0, ppm_pkg::PPM_OFS_DIR, 0);
    `CHK("dir", 32'h0000_0000, rd)
    final_report();
  end
endmodule // ppm_port_test
`default_nettype wire
